//--- inc/gie_pkg.sv
package gie_pkg;

  ////////////////////////////////////////////////////////////////////////////
  // Sizes
  localparam int NUM_GROUPS = 12;
  localparam int GROUP_SIZE = 8;
  localparam int NUM_SRC = 96;
  localparam int NUM_DIRECT = 4;
  localparam int VEC_W = 32;
  localparam int SRC_W = 7;
  localparam int GRP_W = 4;
  localparam int IDX_W = 3;
  localparam int AXI_AW = 12;
  localparam int AXI_DW = 32;

  ////////////////////////////////////////////////////////////////////////////
  // Register map, byte addresses
  localparam logic [11:0] FLAG_BASE = 12'h000;
  localparam logic [11:0] FLAG_END = 12'h030;
  localparam logic [11:0] EN_BASE = 12'h040;
  localparam logic [11:0] EN_END = 12'h070;
  localparam logic [11:0] ACK_ADDR = 12'h080;
  localparam logic [11:0] VEC_BASE = 12'h200;
  localparam logic [11:0] VEC_END = 12'h380;

  ////////////////////////////////////////////////////////////////////////////
  // Bus answers and reset values
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
  localparam logic [95:0] SRC_BITS_RST = 96'h0;
  localparam logic [11:0] GRP_BITS_RST = 12'h000;
  localparam logic [31:0] WORD_RST = 32'h0000_0000;

  ////////////////////////////////////////////////////////////////////////////
  // Types
  typedef enum logic [2:0] {
    REG_NONE = 3'h0,
    REG_FLAG = 3'h1,
    REG_EN = 3'h2,
    REG_ACK = 3'h3,
    REG_VEC = 3'h4
  } gie_region_t;

  typedef struct packed {
    gie_region_t region;
    logic [6:0] idx;
  } gie_dec_t;

  typedef enum logic [2:0] {
    RD_IDLE = 3'b001,
    RD_FETCH = 3'b010,
    RD_RESP = 3'b100
  } gie_rd_state_t;

  // Vector fetch from the processor
  typedef struct packed {
    logic valid;
    logic [3:0] group;
  } gie_fetch_req_t;

  // Vector returned to the processor
  typedef struct packed {
    logic valid;
    logic [6:0] src;
    logic [31:0] vector;
  } gie_fetch_rsp_t;

endpackage : gie_pkg

//--- src/gie_prio_enc.sv
`timescale 1ns/1ps
module gie_prio_enc #(
  parameter int WIDTH = 8,
  parameter int IDX_W = 3
) (
  input wire logic [WIDTH-1:0] pend,
  output logic [IDX_W-1:0] idx,
  output logic hit
);

  ////////////////////////////////////////////////////////////////////////////
  // Lowest set bit wins, index 0 when nothing pends
  always_comb
  begin
    idx = '0;
    hit = 1'b0;
    for (int i = WIDTH - 1; i >= 0; i--)
    begin
      if (pend[i])
      begin
        idx = IDX_W'(i);
        hit = 1'b1;
      end
    end
  end

endmodule : gie_prio_enc

//--- src/gie_vec_ram.sv
`timescale 1ns/1ps
module gie_vec_ram #(
  parameter int DEPTH = 96,
  parameter int AW = 7,
  parameter int WIDTH = 32
) (
  input wire logic sys_clk,
  input wire logic srst,
  input wire logic wr_en,
  input wire logic [AW-1:0] wr_addr,
  input wire logic [WIDTH-1:0] wr_data,
  input wire logic [WIDTH/8-1:0] wr_strb,
  input wire logic [AW-1:0] rd_a_addr,
  output logic [WIDTH-1:0] rd_a_data,
  input wire logic [AW-1:0] rd_b_addr,
  output logic [WIDTH-1:0] rd_b_data
);

  logic [WIDTH-1:0] mem [DEPTH];

  ////////////////////////////////////////////////////////////////////////////
  // Byte-lane writes, one process owns the whole array
  always_ff @(posedge sys_clk)
  begin
    for (int b = 0; b < WIDTH / 8; b++)
    begin
      if (wr_en && wr_strb[b] && (int'(wr_addr) < DEPTH))
        mem[wr_addr][b*8 +: 8] <= wr_data[b*8 +: 8];
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Two registered read ports, out-of-range reads give zero
  always_ff @(posedge sys_clk)
  begin
    if (srst)
    begin
      rd_a_data <= '0;
      rd_b_data <= '0;
    end
    else
    begin
      rd_a_data <= (int'(rd_a_addr) < DEPTH) ? mem[rd_a_addr] : '0;
      rd_b_data <= (int'(rd_b_addr) < DEPTH) ? mem[rd_b_addr] : '0;
    end
  end

endmodule : gie_vec_ram

//--- src/gie_expander.sv
// Register access over AXI4-Lite and the address map are this design's own decisions.
`timescale 1ns/1ps
// What this block does
// - 96 requests, twelve groups of eight
// - Group x drives processor line x
// - Ungrouped lines pass straight through
// - Per group flag and enable registers
// - One acknowledge bit per group
// - Source request sets flag regardless enable
// - Flag, enable, no ack raise line
// - Ack set holds request until cleared
// - Fetch picks lowest flagged enabled source
// - Nothing pending returns vector of group's index 0 source
// - Decode uses flags, enables at fetch
// - Writable 32-bit vector per source
// - Vectors kept in dedicated RAM
// - Fetch clears chosen source flag
module gie_expander #(
  parameter int NUM_GROUPS = gie_pkg::NUM_GROUPS,
  parameter int NUM_DIRECT = gie_pkg::NUM_DIRECT
) (
  input wire logic sys_clk,
  input wire logic srst,
  input wire logic [gie_pkg::NUM_SRC-1:0] periph_req,
  input wire logic [NUM_DIRECT-1:0] direct_req,
  output logic [NUM_DIRECT-1:0] direct_line,
  output logic [NUM_GROUPS-1:0] cpu_group_line,
  input wire gie_pkg::gie_fetch_req_t fetch_req,
  output gie_pkg::gie_fetch_rsp_t fetch_rsp,
  input wire logic [gie_pkg::AXI_AW-1:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [gie_pkg::AXI_DW-1:0] s_axi_wdata,
  input wire logic [gie_pkg::AXI_DW/8-1:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [gie_pkg::AXI_AW-1:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [gie_pkg::AXI_DW-1:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready
);

  localparam int NS = gie_pkg::NUM_SRC;
  localparam int GS = gie_pkg::GROUP_SIZE;

  ////////////////////////////////////////////////////////////////////////////
  // Address decode into region and word index
  function automatic gie_pkg::gie_dec_t decode(input logic [gie_pkg::AXI_AW-1:0] a);
    gie_pkg::gie_dec_t r;
    logic [gie_pkg::AXI_AW-1:0] off;
    r.region = gie_pkg::REG_NONE;
    r.idx = 7'h00;
    off = 12'h000;
    if (a >= gie_pkg::FLAG_BASE && a < gie_pkg::FLAG_END)
    begin
      off = a - gie_pkg::FLAG_BASE;
      r.region = gie_pkg::REG_FLAG;
    end
    else if (a >= gie_pkg::EN_BASE && a < gie_pkg::EN_END)
    begin
      off = a - gie_pkg::EN_BASE;
      r.region = gie_pkg::REG_EN;
    end
    else if (a[11:2] == gie_pkg::ACK_ADDR[11:2])
    begin
      r.region = gie_pkg::REG_ACK;
    end
    else if (a >= gie_pkg::VEC_BASE && a < gie_pkg::VEC_END)
    begin
      off = a - gie_pkg::VEC_BASE;
      r.region = gie_pkg::REG_VEC;
    end
    r.idx = off[8:2];
    return r;
  endfunction : decode

  ////////////////////////////////////////////////////////////////////////////
  // Declarations
  logic [NS-1:0] req_prev_q, req_prev_d;
  logic [NS-1:0] flag_q, flag_d;
  logic [NS-1:0] en_q, en_d;
  logic [NUM_GROUPS-1:0] ack_q, ack_d;
  logic [NUM_GROUPS-1:0] line_q, line_d;
  logic [NS-1:0] req_rise;
  logic [NUM_GROUPS-1:0][GS-1:0] grp_pend;
  logic [GS-1:0] fetch_pend;
  logic fetch_in_range;
  logic [gie_pkg::IDX_W-1:0] win_idx;
  logic win_hit;
  logic [gie_pkg::SRC_W-1:0] win_src;
  logic rsp_valid_q, rsp_valid_d;
  logic [gie_pkg::SRC_W-1:0] rsp_src_q, rsp_src_d;
  logic [gie_pkg::VEC_W-1:0] ram_a_data, ram_b_data;
  logic aw_have_q, aw_have_d;
  logic [gie_pkg::AXI_AW-1:0] aw_addr_q, aw_addr_d;
  logic w_have_q, w_have_d;
  logic [gie_pkg::AXI_DW-1:0] w_data_q, w_data_d;
  logic [gie_pkg::AXI_DW/8-1:0] w_strb_q, w_strb_d;
  logic bvalid_q, bvalid_d;
  logic [1:0] bresp_q, bresp_d;
  logic do_write;
  gie_pkg::gie_dec_t wr_dec, rd_dec;
  gie_pkg::gie_rd_state_t rd_state_q, rd_state_d;
  logic [gie_pkg::AXI_AW-1:0] ar_addr_q, ar_addr_d;
  logic [gie_pkg::AXI_DW-1:0] rdata_q, rdata_d;
  logic [1:0] rresp_q, rresp_d;

  ////////////////////////////////////////////////////////////////////////////
  // Ungrouped lines bypass all gating
  assign direct_line = direct_req;

  ////////////////////////////////////////////////////////////////////////////
  // Rising edge of each source request
  assign req_rise = periph_req & ~req_prev_q;

  ////////////////////////////////////////////////////////////////////////////
  // Per group pending set and line drive
  for (genvar g = 0; g < NUM_GROUPS; g++)
  begin : g_group
    assign grp_pend[g] = flag_q[g*GS +: GS] & en_q[g*GS +: GS];
    assign line_d[g] = (|grp_pend[g]) & ~ack_q[g];
  end

  ////////////////////////////////////////////////////////////////////////////
  // Vector fetch decode, taken from current flag and enable contents
  assign fetch_in_range = fetch_req.valid && (int'(fetch_req.group) < NUM_GROUPS);
  assign fetch_pend = fetch_in_range ? grp_pend[fetch_req.group] : '0;

  gie_prio_enc #(
    .WIDTH(GS),
    .IDX_W(gie_pkg::IDX_W)
  ) u_prio (
    .pend(fetch_pend),
    .idx(win_idx),
    .hit(win_hit)
  );

  // Index 0 of the fetched group wins when nothing pends
  assign win_src = {fetch_req.group, win_idx};

  ////////////////////////////////////////////////////////////////////////////
  // Flag, enable and acknowledge next values
  always_comb
  begin
    req_prev_d = periph_req;
    flag_d = flag_q;
    en_d = en_q;
    ack_d = ack_q;
    // Fetch clears the winner's flag
    if (fetch_in_range && win_hit)
      flag_d[win_src] = 1'b0;
    // A new request beats the clear
    flag_d = flag_d | req_rise;
    // Enable writes from software
    if (do_write && wr_dec.region == gie_pkg::REG_EN && w_strb_q[0])
      en_d[{wr_dec.idx[3:0], 3'h0} +: GS] = w_data_q[GS-1:0];
    // Write one clears an acknowledge bit
    if (do_write && wr_dec.region == gie_pkg::REG_ACK)
    begin
      if (w_strb_q[0])
        ack_d[7:0] = ack_d[7:0] & ~w_data_q[7:0];
      if (w_strb_q[1])
        ack_d[NUM_GROUPS-1:8] = ack_d[NUM_GROUPS-1:8] & ~w_data_q[NUM_GROUPS-1:8];
    end
    // Delivery sets the acknowledge bit, set wins over clear
    if (fetch_in_range)
      ack_d[fetch_req.group] = 1'b1;
  end

  // Reset leaves every group silent
  always_ff @(posedge sys_clk)
  begin
    if (srst)
    begin
      req_prev_q <= gie_pkg::SRC_BITS_RST;
      flag_q <= gie_pkg::SRC_BITS_RST;
      en_q <= gie_pkg::SRC_BITS_RST;
      ack_q <= gie_pkg::GRP_BITS_RST;
      line_q <= gie_pkg::GRP_BITS_RST;
    end
    else
    begin
      req_prev_q <= req_prev_d;
      flag_q <= flag_d;
      en_q <= en_d;
      ack_q <= ack_d;
      line_q <= line_d;
    end
  end

  assign cpu_group_line = line_q;

  ////////////////////////////////////////////////////////////////////////////
  // Fetch answer, vector comes from the RAM read register
  always_comb
  begin
    rsp_valid_d = fetch_req.valid;
    rsp_src_d = fetch_in_range ? win_src : 7'h00;
  end

  always_ff @(posedge sys_clk)
  begin
    if (srst)
    begin
      rsp_valid_q <= 1'b0;
      rsp_src_q <= 7'h00;
    end
    else
    begin
      rsp_valid_q <= rsp_valid_d;
      rsp_src_q <= rsp_src_d;
    end
  end

  assign fetch_rsp.valid = rsp_valid_q;
  assign fetch_rsp.src = rsp_src_q;
  assign fetch_rsp.vector = ram_a_data;

  ////////////////////////////////////////////////////////////////////////////
  // Vector RAM, port A for fetches, port B for bus reads
  gie_vec_ram #(
    .DEPTH(NS),
    .AW(gie_pkg::SRC_W),
    .WIDTH(gie_pkg::VEC_W)
  ) u_vec_ram (
    .sys_clk(sys_clk),
    .srst(srst),
    .wr_en(do_write && wr_dec.region == gie_pkg::REG_VEC),
    .wr_addr(wr_dec.idx),
    .wr_data(w_data_q),
    .wr_strb(w_strb_q),
    .rd_a_addr(fetch_in_range ? win_src : 7'h00),
    .rd_a_data(ram_a_data),
    .rd_b_addr(rd_dec.idx),
    .rd_b_data(ram_b_data)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Write channel: hold address and data, answer after both
  assign s_axi_awready = ~aw_have_q & ~bvalid_q;
  assign s_axi_wready = ~w_have_q & ~bvalid_q;
  assign do_write = aw_have_q & w_have_q & ~bvalid_q;
  assign wr_dec = decode(aw_addr_q);

  always_comb
  begin
    aw_have_d = aw_have_q;
    aw_addr_d = aw_addr_q;
    w_have_d = w_have_q;
    w_data_d = w_data_q;
    w_strb_d = w_strb_q;
    bvalid_d = bvalid_q;
    bresp_d = bresp_q;
    if (s_axi_awvalid && s_axi_awready)
    begin
      aw_have_d = 1'b1;
      aw_addr_d = s_axi_awaddr;
    end
    if (s_axi_wvalid && s_axi_wready)
    begin
      w_have_d = 1'b1;
      w_data_d = s_axi_wdata;
      w_strb_d = s_axi_wstrb;
    end
    if (do_write)
    begin
      aw_have_d = 1'b0;
      w_have_d = 1'b0;
      bvalid_d = 1'b1;
      bresp_d = (wr_dec.region == gie_pkg::REG_NONE) ? gie_pkg::RESP_SLVERR : gie_pkg::RESP_OKAY;
    end
    if (bvalid_q && s_axi_bready)
      bvalid_d = 1'b0;
  end

  always_ff @(posedge sys_clk)
  begin
    if (srst)
    begin
      aw_have_q <= 1'b0;
      aw_addr_q <= 12'h000;
      w_have_q <= 1'b0;
      w_data_q <= gie_pkg::WORD_RST;
      w_strb_q <= 4'h0;
      bvalid_q <= 1'b0;
      bresp_q <= gie_pkg::RESP_OKAY;
    end
    else
    begin
      aw_have_q <= aw_have_d;
      aw_addr_q <= aw_addr_d;
      w_have_q <= w_have_d;
      w_data_q <= w_data_d;
      w_strb_q <= w_strb_d;
      bvalid_q <= bvalid_d;
      bresp_q <= bresp_d;
    end
  end

  assign s_axi_bvalid = bvalid_q;
  assign s_axi_bresp = bresp_q;

  ////////////////////////////////////////////////////////////////////////////
  // Read channel: take address, wait for RAM, answer
  assign s_axi_arready = (rd_state_q == gie_pkg::RD_IDLE);
  assign rd_dec = decode((rd_state_q == gie_pkg::RD_IDLE) ? s_axi_araddr : ar_addr_q);

  always_comb
  begin
    rd_state_d = rd_state_q;
    ar_addr_d = ar_addr_q;
    rdata_d = rdata_q;
    rresp_d = rresp_q;
    unique case (rd_state_q)
      gie_pkg::RD_IDLE:
      begin
        if (s_axi_arvalid)
        begin
          ar_addr_d = s_axi_araddr;
          rd_state_d = gie_pkg::RD_FETCH;
        end
      end
      gie_pkg::RD_FETCH:
      begin
        rresp_d = gie_pkg::RESP_OKAY;
        rdata_d = gie_pkg::WORD_RST;
        unique case (rd_dec.region)
          gie_pkg::REG_FLAG: rdata_d[GS-1:0] = flag_q[{rd_dec.idx[3:0], 3'h0} +: GS];
          gie_pkg::REG_EN: rdata_d[GS-1:0] = en_q[{rd_dec.idx[3:0], 3'h0} +: GS];
          gie_pkg::REG_ACK: rdata_d[NUM_GROUPS-1:0] = ack_q;
          gie_pkg::REG_VEC: rdata_d = ram_b_data;
          gie_pkg::REG_NONE: rresp_d = gie_pkg::RESP_SLVERR;
          default: rresp_d = gie_pkg::RESP_SLVERR;
        endcase
        rd_state_d = gie_pkg::RD_RESP;
      end
      gie_pkg::RD_RESP:
      begin
        if (s_axi_rready)
          rd_state_d = gie_pkg::RD_IDLE;
      end
      default: rd_state_d = gie_pkg::RD_IDLE;
    endcase
  end

  always_ff @(posedge sys_clk)
  begin
    if (srst)
    begin
      rd_state_q <= gie_pkg::RD_IDLE;
      ar_addr_q <= 12'h000;
      rdata_q <= gie_pkg::WORD_RST;
      rresp_q <= gie_pkg::RESP_OKAY;
    end
    else
    begin
      rd_state_q <= rd_state_d;
      ar_addr_q <= ar_addr_d;
      rdata_q <= rdata_d;
      rresp_q <= rresp_d;
    end
  end

  assign s_axi_rvalid = (rd_state_q == gie_pkg::RD_RESP);
  assign s_axi_rdata = rdata_q;
  assign s_axi_rresp = rresp_q;

endmodule : gie_expander

//--- testbench/gie_expander_properties.sv
`timescale 1ns/1ps
module gie_checker #(
  parameter int NUM_GROUPS = 12,
  parameter int NUM_DIRECT = 4
) (
  input wire logic sys_clk,
  input wire logic srst,
  input wire logic [NUM_DIRECT-1:0] direct_req,
  input wire logic [NUM_DIRECT-1:0] direct_line,
  input wire logic [NUM_GROUPS-1:0] cpu_group_line,
  input wire gie_pkg::gie_fetch_req_t fetch_req,
  input wire gie_pkg::gie_fetch_rsp_t fetch_rsp,
  input wire logic s_axi_awvalid,
  input wire logic s_axi_awready,
  input wire logic s_axi_wvalid,
  input wire logic s_axi_wready,
  input wire logic s_axi_bvalid,
  input wire logic s_axi_arvalid,
  input wire logic s_axi_arready,
  input wire logic s_axi_rvalid
);
  ////////////////////////////////////////
  // Steps of a fetch and of bus transfers
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (srst);
  sequence s_fetch; fetch_req.valid && (fetch_req.group < 4'hC); endsequence
  sequence s_ar; s_axi_arvalid && s_axi_arready; endsequence
  sequence s_aw_w; s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready; endsequence
  property p_direct; direct_line == direct_req; endproperty
  property p_rsp; fetch_req.valid |=> fetch_rsp.valid; endproperty
  property p_src; s_fetch |=> fetch_rsp.src[6:3] == $past(fetch_req.group); endproperty
  property p_ack; s_fetch |-> ##2 !cpu_group_line[$past(fetch_req.group, 2)]; endproperty
  property p_reset; $fell(srst) |-> (cpu_group_line == '0) && !fetch_rsp.valid; endproperty
  property p_ar; s_ar |=> !s_axi_rvalid ##1 s_axi_rvalid; endproperty
  property p_ar_busy; s_ar |=> !s_axi_arready; endproperty
  property p_b; s_aw_w |=> !s_axi_bvalid ##1 s_axi_bvalid; endproperty
  property p_aw_busy; s_aw_w |=> !s_axi_awready && !s_axi_wready; endproperty
  ////////////////////////////////////////
  a_direct: assert property (p_direct)
    else $error("direct line differs from request");
  a_rsp: assert property (p_rsp)
    else $error("no vector answer after fetch");
  a_src: assert property (p_src)
    else $error("answered source outside fetched group");
  a_ack: assert property (p_ack)
    else $error("line still high after fetch");
  a_reset: assert property (p_reset)
    else $error("outputs active after reset");
  a_ar: assert property (p_ar)
    else $error("read answer late or early");
  a_ar_busy: assert property (p_ar_busy)
    else $error("read address taken while busy");
  a_b: assert property (p_b)
    else $error("write answer missing");
  a_aw_busy: assert property (p_aw_busy)
    else $error("write taken while answer pending");
endmodule : gie_checker

bind gie_expander gie_checker #(.NUM_GROUPS(NUM_GROUPS), .NUM_DIRECT(NUM_DIRECT)) u_chk (
  .sys_clk(sys_clk), .srst(srst), .direct_req(direct_req), .direct_line(direct_line),
  .cpu_group_line(cpu_group_line), .fetch_req(fetch_req), .fetch_rsp(fetch_rsp),
  .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready), .s_axi_wvalid(s_axi_wvalid),
  .s_axi_wready(s_axi_wready), .s_axi_bvalid(s_axi_bvalid), .s_axi_arvalid(s_axi_arvalid),
  .s_axi_arready(s_axi_arready), .s_axi_rvalid(s_axi_rvalid)
);

//--- testbench/gie_cpu_model.sv
`timescale 1ns/1ps
module gie_cpu_model (
  input wire logic sys_clk,
  input wire logic srst,
  input wire logic [11:0] cpu_group_line,
  input wire logic global_int_mask,
  input wire logic debug_halt,
  input wire logic [11:0] debug_line_enable,
  input wire logic [11:0] cpu_line_enable,
  output gie_pkg::gie_fetch_req_t fetch_req
);
  logic [11:0] line_prev_q;
  logic [11:0] cpu_line_flag_q;
  logic [11:0] ready_lines;
  logic [3:0] wait_q;
  logic [3:0] grp_q;
  logic busy_q;
  logic [3:0] pick;
  ////////////////////////////////////////
  // Lowest latched and enabled line wins
  always_comb
  begin
    ready_lines = cpu_line_flag_q & cpu_line_enable;
    // Halted debug ignores the global mask
    if (debug_halt)
      ready_lines = ready_lines & debug_line_enable;
    else if (global_int_mask)
      ready_lines = 12'h000;
    pick = 4'h0;
    for (int k = 11; k >= 0; k--)
    begin
      if (ready_lines[k])
        pick = 4'(k);
    end
  end
  ////////////////////////////////////////
  // Latch line edges, service, fetch late
  always_ff @(posedge sys_clk)
  begin
    fetch_req <= '0;
    line_prev_q <= cpu_group_line;
    if (srst)
    begin
      cpu_line_flag_q <= 12'h000;
      busy_q <= 1'b0;
      wait_q <= 4'h0;
      grp_q <= 4'h0;
    end
    else
    begin
      cpu_line_flag_q <= cpu_line_flag_q | (cpu_group_line & ~line_prev_q);
      if (busy_q)
      begin
        wait_q <= wait_q + 4'h1;
        if (wait_q == 4'h8)
        begin
          fetch_req.valid <= 1'b1;
          fetch_req.group <= grp_q;
          busy_q <= 1'b0;
        end
      end
      else if (|ready_lines)
      begin
        busy_q <= 1'b1;
        wait_q <= 4'h0;
        grp_q <= pick;
        cpu_line_flag_q[pick] <= 1'b0;
      end
    end
  end
endmodule : gie_cpu_model

//--- testbench/tb_top.sv
`timescale 1ns/1ps
module tb_top;
  logic sys_clk = 1'b0;
  logic srst = 1'b1;
  logic [95:0] periph_req = '0;
  logic [3:0] direct_req = 4'h0;
  logic [3:0] direct_line;
  logic [11:0] cpu_group_line;
  logic global_int_mask = 1'b1;
  logic debug_halt = 1'b0;
  logic [1:0] wr_resp;
  gie_pkg::gie_fetch_req_t fetch_req;
  gie_pkg::gie_fetch_rsp_t fetch_rsp;
  logic [11:0] awaddr = '0;
  logic [11:0] araddr = '0;
  logic [31:0] wdata = '0;
  logic [31:0] rdata;
  logic awvalid = 1'b0;
  logic wvalid = 1'b0;
  logic arvalid = 1'b0;
  logic awready, wready, bvalid, arready, rvalid;
  logic [1:0] bresp, rresp;
  int bad_count = 0;
  int comparisons = 0;
  int cycles = 0;
  ////////////////////////////////////////
  // Clock, design and processor model
  always #12.5 sys_clk = ~sys_clk;
  gie_expander dut (
    .sys_clk(sys_clk), .srst(srst), .periph_req(periph_req), .direct_req(direct_req),
    .direct_line(direct_line), .cpu_group_line(cpu_group_line), .fetch_req(fetch_req),
    .fetch_rsp(fetch_rsp), .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
    .s_axi_wdata(wdata), .s_axi_wstrb(4'hF), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
    .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(1'b1), .s_axi_araddr(araddr),
    .s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp),
    .s_axi_rvalid(rvalid), .s_axi_rready(1'b1)
  );
  gie_cpu_model u_cpu (
    .sys_clk(sys_clk), .srst(srst), .cpu_group_line(cpu_group_line),
    .global_int_mask(global_int_mask), .debug_halt(debug_halt), .debug_line_enable(12'h001),
    .cpu_line_enable(12'hFFF), .fetch_req(fetch_req)
  );
  ////////////////////////////////////////
  // Verdict, compare and bus tasks
  task automatic print_verdict;
    if (bad_count == 0 && comparisons > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask : print_verdict
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    comparisons++;
    if (seen !== exp)
    begin
      bad_count++;
      $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : chk
  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    logic aw_hs;
    logic w_hs;
    logic b_hs;
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    b_hs = 1'b0;
    while (!b_hs)
    begin
      @(negedge sys_clk);
      aw_hs = awvalid && awready;
      w_hs = wvalid && wready;
      b_hs = bvalid;
      wr_resp = bresp;
      @(posedge sys_clk);
      if (aw_hs)
        awvalid <= 1'b0;
      if (w_hs)
        wvalid <= 1'b0;
    end
  endtask : wr
  task automatic rd(input logic [11:0] a, output logic [31:0] d, output logic [1:0] r);
    logic ar_hs;
    logic r_hs;
    araddr <= a;
    arvalid <= 1'b1;
    r_hs = 1'b0;
    while (!r_hs)
    begin
      @(negedge sys_clk);
      ar_hs = arvalid && arready;
      r_hs = rvalid;
      d = rdata;
      r = rresp;
      @(posedge sys_clk);
      if (ar_hs)
        arvalid <= 1'b0;
    end
  endtask : rd
  task automatic rchk(input logic [11:0] a, input logic [31:0] exp);
    logic [31:0] d;
    logic [1:0] r;
    rd(a, d, r);
    chk(d, exp);
  endtask : rchk
  task automatic fchk(input logic [6:0] s);
    @(negedge sys_clk);
    while (fetch_rsp.valid !== 1'b1)
      @(negedge sys_clk);
    chk({25'h0, fetch_rsp.src}, {25'h0, s});
    chk(fetch_rsp.vector, {16'hC0DE, 9'h0, s});
    @(posedge sys_clk);
  endtask : fchk
  ////////////////////////////////////////
  // Hang guard
  always @(posedge sys_clk)
  begin
    cycles++;
    if (cycles == 5000)
    begin
      bad_count++;
      print_verdict;
    end
  end
  ////////////////////////////////////////
  // Main sequence
  initial
  begin
    logic [31:0] d;
    logic [1:0] r;
    repeat (16) @(posedge sys_clk);
    srst <= 1'b0;
    @(posedge sys_clk);
    rchk(gie_pkg::EN_BASE, 32'h0);
    rchk(gie_pkg::ACK_ADDR, 32'h0);
    rchk(gie_pkg::FLAG_BASE + 12'h02C, 32'h0);
    rd(12'h0FC, d, r);
    chk({30'h0, r}, {30'h0, gie_pkg::RESP_SLVERR});
    for (int i = 0; i < 96; i++)
      wr(gie_pkg::VEC_BASE + 12'(4 * i), {16'hC0DE, 16'(i)});
    wr(gie_pkg::EN_BASE, 32'h0000_000A);
    global_int_mask <= 1'b0;
    periph_req <= 96'hB;
    rchk(gie_pkg::FLAG_BASE, 32'h0000_000B);
    fchk(7'h01);
    rchk(gie_pkg::FLAG_BASE, 32'h0000_0009);
    rchk(gie_pkg::ACK_ADDR, 32'h0000_0001);
    repeat (20) @(posedge sys_clk);
    @(negedge sys_clk);
    chk({31'h0, cpu_group_line[0]}, 32'h0);
    @(posedge sys_clk);
    wr(gie_pkg::ACK_ADDR, 32'h0000_0001);
    fchk(7'h03);
    global_int_mask <= 1'b1;
    periph_req <= 96'h0;
    @(posedge sys_clk);
    periph_req <= 96'h2;
    wr(gie_pkg::EN_BASE, 32'h0000_0002);
    wr(gie_pkg::ACK_ADDR, 32'h0000_0001);
    repeat (3) @(posedge sys_clk);
    @(negedge sys_clk);
    chk({31'h0, cpu_group_line[0]}, 32'h1);
    @(posedge sys_clk);
    wr(gie_pkg::EN_BASE, 32'h0);
    debug_halt <= 1'b1;
    fchk(7'h00);
    debug_halt <= 1'b0;
    global_int_mask <= 1'b0;
    rchk(gie_pkg::FLAG_BASE, 32'h0000_0003);
    wr(gie_pkg::EN_BASE + 12'h02C, 32'h0000_0080);
    periph_req[95] <= 1'b1;
    fchk(7'h5F);
    rchk(gie_pkg::ACK_ADDR, 32'h0000_0801);
    wr(gie_pkg::ACK_ADDR, 32'h0000_0FFF);
    rchk(gie_pkg::ACK_ADDR, 32'h0);
    wr(gie_pkg::FLAG_BASE, 32'h0000_00FF);
    chk({30'h0, wr_resp}, {30'h0, gie_pkg::RESP_OKAY});
    wr(12'h0FC, 32'h0000_0001);
    chk({30'h0, wr_resp}, {30'h0, gie_pkg::RESP_SLVERR});
    rchk(gie_pkg::FLAG_BASE, 32'h0000_0003);
    direct_req <= 4'hA;
    @(negedge sys_clk);
    chk({28'h0, direct_line}, 32'hA);
    print_verdict;
  end
endmodule : tb_top
